// ---- hdl/gpfgh_pkg.sv ----
// Constants shared by the three-port GPIO block
package gpfgh_pkg;
  localparam int F_W = 8;
  localparam int G_W = 16;
  localparam int H_W = 11;
  localparam int IRQ_LINE_W = 24;

  // Byte addresses of the register words
  localparam logic [31:0] ADDR_F_CON = 32'h5600_0050;
  localparam logic [31:0] ADDR_F_DAT = 32'h5600_0054;
  localparam logic [31:0] ADDR_F_UP = 32'h5600_0058;
  localparam logic [31:0] ADDR_G_CON = 32'h5600_0060;
  localparam logic [31:0] ADDR_G_DAT = 32'h5600_0064;
  localparam logic [31:0] ADDR_G_UP = 32'h5600_0068;
  localparam logic [31:0] ADDR_H_CON = 32'h5600_0070;
  localparam logic [31:0] ADDR_H_DAT = 32'h5600_0074;
  localparam logic [31:0] ADDR_H_UP = 32'h5600_0078;

  // Reset values
  localparam logic [2*F_W-1:0] F_CON_RST = 16'h0000;
  localparam logic [2*G_W-1:0] G_CON_RST = 32'h0000_0000;
  localparam logic [2*H_W-1:0] H_CON_RST = 22'h00_0000;
  localparam logic [F_W-1:0] F_DAT_RST = 8'h00;
  localparam logic [G_W-1:0] G_DAT_RST = 16'h0000;
  localparam logic [H_W-1:0] H_DAT_RST = 11'h000;
  localparam logic [F_W-1:0] F_UP_RST = 8'h00;
  localparam logic [G_W-1:0] G_UP_RST = 16'hFC00;
  localparam logic [H_W-1:0] H_UP_RST = 11'h000;
  localparam logic [31:0] RDATA_RST = 32'h0000_0000;

  // Pin function codes
  localparam logic [1:0] FN_INPUT = 2'h0;
  localparam logic [1:0] FN_OUTPUT = 2'h1;
  localparam logic [1:0] FN_ALT2 = 2'h2;
  localparam logic [1:0] FN_ALT3 = 2'h3;

  // Pins on which code 10 / code 11 select a real function
  localparam logic [F_W-1:0] F_ALT2_MASK = 8'hFF;
  localparam logic [F_W-1:0] F_ALT3_MASK = 8'h00;
  localparam logic [G_W-1:0] G_ALT2_MASK = 16'hFFFF;
  localparam logic [G_W-1:0] G_ALT3_MASK = 16'h0EFC;
  localparam logic [H_W-1:0] H_ALT2_MASK = 11'h7FF;
  localparam logic [H_W-1:0] H_ALT3_MASK = 11'h0C0;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b01,
    ST_RESP = 2'b10
  } gpfgh_state_t;
endpackage

// ---- hdl/gpfgh_port.sv ----
// Per-port pin multiplexer with registered pad and peripheral outputs
`timescale 1ns/1ps
`default_nettype none
module gpfgh_port
  import gpfgh_pkg::*;
#(
  parameter int W = 8,
  parameter logic [W-1:0] ALT2_MASK = '1,
  parameter logic [W-1:0] ALT3_MASK = '0,
  parameter logic [W-1:0] UP_RST = '0
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [2*W-1:0] con,
  input wire logic [W-1:0] dat,
  input wire logic [W-1:0] up,
  input wire logic [W-1:0] pin_in,
  input wire logic [W-1:0] alt2_out,
  input wire logic [W-1:0] alt2_oe,
  input wire logic [W-1:0] alt3_out,
  input wire logic [W-1:0] alt3_oe,
  output logic [W-1:0] rd_level,
  output logic [W-1:0] pin_out,
  output logic [W-1:0] pin_oe,
  output logic [W-1:0] pullup_en,
  output logic [W-1:0] alt2_in,
  output logic [W-1:0] alt3_in
);
  logic [W-1:0] is_out;
  logic [W-1:0] is_a2;
  logic [W-1:0] is_a3;
  logic [W-1:0] nxt_pin_out;
  logic [W-1:0] nxt_pin_oe;

  ////////////////////////////////////////////////////////////////////////////
  for (genvar i = 0; i < W; i++) begin : g_pin
    assign is_out[i] = con[2*i +: 2] == FN_OUTPUT;
    // Reserved codes leave the pad undriven and the peripheral blind
    assign is_a2[i] = (con[2*i +: 2] == FN_ALT2) && ALT2_MASK[i];
    assign is_a3[i] = (con[2*i +: 2] == FN_ALT3) && ALT3_MASK[i];
  end

  assign nxt_pin_out = (is_out & dat) | (is_a2 & alt2_out) | (is_a3 & alt3_out);
  assign nxt_pin_oe = is_out | (is_a2 & alt2_oe) | (is_a3 & alt3_oe);
  // Function pins return the pad level; software must not rely on it
  assign rd_level = (is_out & dat) | (~is_out & pin_in);

  ////////////////////////////////////////////////////////////////////////////
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pin_out <= '0;
      pin_oe <= '0;
      pullup_en <= ~UP_RST;
      alt2_in <= '0;
      alt3_in <= '0;
    end else begin
      pin_out <= nxt_pin_out;
      pin_oe <= nxt_pin_oe;
      pullup_en <= ~up;
      alt2_in <= pin_in & is_a2;
      alt3_in <= pin_in & is_a3;
    end
  end
endmodule
`default_nettype wire

// ---- hdl/gpfgh_top.sv ----
// APB register file and pin control for three general-purpose ports
// Notes on behaviour
// - First port: 2-bit function per pin, reset 0
// - Second port: 16 fields, 10 gives lines 8-23
// - Second port code 11 peripheral pin functions
// - Input pin: data read returns pin level
// - Output pin drives its data register bit
// - Function pin: data read value undefined
// - Pull-up on when control bit is 0
// - First-port pull-up control resets to zero
// - Second-port pull-up control resets to FC00
// - Third-port pull-up control resets to zero
//
// The implementer's own choice: register access over APB.
`timescale 1ns/1ps
`default_nettype none
module gpfgh_top
  import gpfgh_pkg::*;
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [gpfgh_pkg::F_W-1:0] first_port_pins_in,
  output logic [gpfgh_pkg::F_W-1:0] first_port_pins_out,
  output logic [gpfgh_pkg::F_W-1:0] first_port_pins_oe,
  output logic [gpfgh_pkg::F_W-1:0] first_port_pins_pullup_en,
  input wire logic [gpfgh_pkg::G_W-1:0] second_port_pins_in,
  output logic [gpfgh_pkg::G_W-1:0] second_port_pins_out,
  output logic [gpfgh_pkg::G_W-1:0] second_port_pins_oe,
  output logic [gpfgh_pkg::G_W-1:0] second_port_pins_pullup_en,
  input wire logic [gpfgh_pkg::H_W-1:0] third_port_pins_in,
  output logic [gpfgh_pkg::H_W-1:0] third_port_pins_out,
  output logic [gpfgh_pkg::H_W-1:0] third_port_pins_oe,
  output logic [gpfgh_pkg::H_W-1:0] third_port_pins_pullup_en,
  output logic [gpfgh_pkg::IRQ_LINE_W-1:0] external_interrupt_line,
  input wire logic [gpfgh_pkg::G_W-1:0] second_port_alt3_out,
  input wire logic [gpfgh_pkg::G_W-1:0] second_port_alt3_oe,
  output logic [gpfgh_pkg::G_W-1:0] second_port_alt3_in,
  input wire logic [gpfgh_pkg::H_W-1:0] third_port_alt2_out,
  input wire logic [gpfgh_pkg::H_W-1:0] third_port_alt2_oe,
  output logic [gpfgh_pkg::H_W-1:0] third_port_alt2_in,
  input wire logic [gpfgh_pkg::H_W-1:0] third_port_alt3_out,
  input wire logic [gpfgh_pkg::H_W-1:0] third_port_alt3_oe,
  output logic [gpfgh_pkg::H_W-1:0] third_port_alt3_in
);
  import gpfgh_pkg::*;

  function automatic logic hit(input logic [31:0] addr, input logic [31:0] base);
    hit = addr == base;
  endfunction

  gpfgh_state_t state_ff;
  gpfgh_state_t nxt_state;
  logic [2*F_W-1:0] f_con_ff;
  logic [F_W-1:0] f_dat_ff;
  logic [F_W-1:0] f_up_ff;
  logic [2*G_W-1:0] g_con_ff;
  logic [G_W-1:0] g_dat_ff;
  logic [G_W-1:0] g_up_ff;
  logic [2*H_W-1:0] h_con_ff;
  logic [H_W-1:0] h_dat_ff;
  logic [H_W-1:0] h_up_ff;
  logic [31:0] prdata_ff;
  logic pready_ff;
  logic pslverr_ff;
  logic [F_W-1:0] f_level;
  logic [G_W-1:0] g_level;
  logic [H_W-1:0] h_level;
  logic [F_W-1:0] f_irq;
  logic [G_W-1:0] g_irq;

  ////////////////////////////////////////////////////////////////////////////
  // Address decode
  // Full 32-bit compare, so an alias above the block never reaches a register
  wire sel_f_con = hit(paddr, ADDR_F_CON);
  wire sel_f_dat = hit(paddr, ADDR_F_DAT);
  wire sel_f_up = hit(paddr, ADDR_F_UP);
  wire sel_g_con = hit(paddr, ADDR_G_CON);
  wire sel_g_dat = hit(paddr, ADDR_G_DAT);
  wire sel_g_up = hit(paddr, ADDR_G_UP);
  wire sel_h_con = hit(paddr, ADDR_H_CON);
  wire sel_h_dat = hit(paddr, ADDR_H_DAT);
  wire sel_h_up = hit(paddr, ADDR_H_UP);
  wire mapped = sel_f_con | sel_f_dat | sel_f_up | sel_g_con | sel_g_dat | sel_g_up
              | sel_h_con | sel_h_dat | sel_h_up;

  // One wait state: the access phase is answered on its second edge
  // The registered answer keeps pready a clean flop output at the cost of a cycle
  wire access = psel & penable;
  wire commit = access & (state_ff == ST_RESP);
  wire wr = commit & pwrite & mapped;

  // Bits above a field's width are dropped on write and read back as zero
  wire [31:0] rd_word =
      ({32{sel_f_con}} & 32'(f_con_ff))
    | ({32{sel_f_dat}} & 32'(f_level))
    | ({32{sel_f_up}} & 32'(f_up_ff))
    | ({32{sel_g_con}} & 32'(g_con_ff))
    | ({32{sel_g_dat}} & 32'(g_level))
    | ({32{sel_g_up}} & 32'(g_up_ff))
    | ({32{sel_h_con}} & 32'(h_con_ff))
    | ({32{sel_h_dat}} & 32'(h_level))
    | ({32{sel_h_up}} & 32'(h_up_ff));

  // Two states only: the second access edge commits and the bus returns to idle
  always_comb begin
    nxt_state = state_ff;
    unique case (state_ff)
      ST_IDLE: begin
        if (access) begin
          nxt_state = ST_RESP;
        end
      end
      ST_RESP: begin
        nxt_state = ST_IDLE;
      end
      default: begin
        nxt_state = ST_IDLE;
      end
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // Bus response
  // Read data is forced to zero outside the answer cycle so no stale word lingers
  // Unmapped words answer with an error and leave every register untouched
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state_ff <= ST_IDLE;
      pready_ff <= 1'b0;
      pslverr_ff <= 1'b0;
      prdata_ff <= RDATA_RST;
    end else begin
      state_ff <= nxt_state;
      pready_ff <= access & (state_ff == ST_IDLE);
      pslverr_ff <= access & (state_ff == ST_IDLE) & ~mapped;
      prdata_ff <= (access & ~pwrite & (state_ff == ST_IDLE)) ? rd_word : RDATA_RST;
    end
  end

  assign prdata = prdata_ff;
  assign pready = pready_ff;
  assign pslverr = pslverr_ff;

  ////////////////////////////////////////////////////////////////////////////
  // First port registers
  // Data bits are stored in every pin mode; a later switch to output shows them
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      f_con_ff <= F_CON_RST;
      f_dat_ff <= F_DAT_RST;
      f_up_ff <= F_UP_RST;
    end else begin
      if (wr & sel_f_con) begin
        f_con_ff <= pwdata[2*F_W-1:0];
      end
      if (wr & sel_f_dat) begin
        f_dat_ff <= pwdata[F_W-1:0];
      end
      if (wr & sel_f_up) begin
        f_up_ff <= pwdata[F_W-1:0];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Second port registers
  // Pull-up control is a disable bit; the port module turns it into an enable
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      g_con_ff <= G_CON_RST;
      g_dat_ff <= G_DAT_RST;
      g_up_ff <= G_UP_RST;
    end else begin
      if (wr & sel_g_con) begin
        g_con_ff <= pwdata[2*G_W-1:0];
      end
      if (wr & sel_g_dat) begin
        g_dat_ff <= pwdata[G_W-1:0];
      end
      if (wr & sel_g_up) begin
        g_up_ff <= pwdata[G_W-1:0];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Third port registers
  // Eleven pins only: the upper code and data bits are not stored
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      h_con_ff <= H_CON_RST;
      h_dat_ff <= H_DAT_RST;
      h_up_ff <= H_UP_RST;
    end else begin
      if (wr & sel_h_con) begin
        h_con_ff <= pwdata[2*H_W-1:0];
      end
      if (wr & sel_h_dat) begin
        h_dat_ff <= pwdata[H_W-1:0];
      end
      if (wr & sel_h_up) begin
        h_up_ff <= pwdata[H_W-1:0];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Pin multiplexers; interrupt lines are inputs only, so code 10 there never drives
  gpfgh_port #(
    .W(F_W),
    .ALT2_MASK(F_ALT2_MASK),
    .ALT3_MASK(F_ALT3_MASK),
    .UP_RST(F_UP_RST)
  ) u_first (
    .clk(clk),
    .rst_n(rst_n),
    .con(f_con_ff),
    .dat(f_dat_ff),
    .up(f_up_ff),
    .pin_in(first_port_pins_in),
    .alt2_out('0),
    .alt2_oe('0),
    .alt3_out('0),
    .alt3_oe('0),
    .rd_level(f_level),
    .pin_out(first_port_pins_out),
    .pin_oe(first_port_pins_oe),
    .pullup_en(first_port_pins_pullup_en),
    .alt2_in(f_irq),
    .alt3_in()
  );

  // Code 11 pins: 11 timer clock 1, 10/9 uart1 cts/rts, 7/6/5 spi1 clk/mosi/miso,
  // 4 panel power-down, 3 spi1 select, 2 spi0 select
  gpfgh_port #(
    .W(G_W),
    .ALT2_MASK(G_ALT2_MASK),
    .ALT3_MASK(G_ALT3_MASK),
    .UP_RST(G_UP_RST)
  ) u_second (
    .clk(clk),
    .rst_n(rst_n),
    .con(g_con_ff),
    .dat(g_dat_ff),
    .up(g_up_ff),
    .pin_in(second_port_pins_in),
    .alt2_out('0),
    .alt2_oe('0),
    .alt3_out(second_port_alt3_out),
    .alt3_oe(second_port_alt3_oe),
    .rd_level(g_level),
    .pin_out(second_port_pins_out),
    .pin_oe(second_port_pins_oe),
    .pullup_en(second_port_pins_pullup_en),
    .alt2_in(g_irq),
    .alt3_in(second_port_alt3_in)
  );

  // Code 10 pins: 10/9 clock outputs 1/0, 8 uart external clock, 7/5/3 uart2/1/0
  // receive, 6/4/2 uart2/1/0 transmit, 1 uart0 rts, 0 uart0 cts.
  // Code 11 pins: 7 uart1 cts, 6 uart1 rts
  gpfgh_port #(
    .W(H_W),
    .ALT2_MASK(H_ALT2_MASK),
    .ALT3_MASK(H_ALT3_MASK),
    .UP_RST(H_UP_RST)
  ) u_third (
    .clk(clk),
    .rst_n(rst_n),
    .con(h_con_ff),
    .dat(h_dat_ff),
    .up(h_up_ff),
    .pin_in(third_port_pins_in),
    .alt2_out(third_port_alt2_out),
    .alt2_oe(third_port_alt2_oe),
    .alt3_out(third_port_alt3_out),
    .alt3_oe(third_port_alt3_oe),
    .rd_level(h_level),
    .pin_out(third_port_pins_out),
    .pin_oe(third_port_pins_oe),
    .pullup_en(third_port_pins_pullup_en),
    .alt2_in(third_port_alt2_in),
    .alt3_in(third_port_alt3_in)
  );

  // Lines 0-7 from the first port, 8-23 from the second in pin order
  // Pins outside code 10 hold their line low, so a stray level raises nothing
  assign external_interrupt_line = {g_irq, f_irq};
endmodule
`default_nettype wire

// ---- verification/gpfgh_pins_model.sv ----
// Board-side model of the pads: pad drive, pull-ups and external drivers
`timescale 1ns/1ps
`default_nettype none
module gpfgh_pins_model #(
  parameter int W = 8
) (
  input wire logic clk,
  input wire logic [W-1:0] pad_out,
  input wire logic [W-1:0] pad_oe,
  input wire logic [W-1:0] pull_en,
  input wire logic [W-1:0] ext_val,
  input wire logic [W-1:0] ext_en,
  output logic [W-1:0] level
);
  logic tgl_ff = 1'b0;
  // A floating pad without pull-up toggles so a stale value never reads as a match
  always_ff @(posedge clk) tgl_ff <= ~tgl_ff;
  assign level = (pad_oe & pad_out) | (~pad_oe & ext_en & ext_val) |
    (~pad_oe & ~ext_en & (pull_en | {W{tgl_ff}}));
endmodule
`default_nettype wire

// ---- verification/gpfgh_top_monitor.sv ----
// Port checker for the three-port GPIO block
`timescale 1ns/1ps
`default_nettype none
module gpfgh_top_monitor
  import gpfgh_pkg::*;
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic [gpfgh_pkg::F_W-1:0] first_port_pins_in,
  input wire logic [gpfgh_pkg::F_W-1:0] first_port_pins_out,
  input wire logic [gpfgh_pkg::F_W-1:0] first_port_pins_oe,
  input wire logic [gpfgh_pkg::F_W-1:0] first_port_pins_pullup_en,
  input wire logic [gpfgh_pkg::G_W-1:0] second_port_pins_in,
  input wire logic [gpfgh_pkg::G_W-1:0] second_port_pins_pullup_en,
  input wire logic [gpfgh_pkg::H_W-1:0] third_port_pins_pullup_en,
  input wire logic [gpfgh_pkg::IRQ_LINE_W-1:0] external_interrupt_line,
  input wire logic [gpfgh_pkg::G_W-1:0] second_port_alt3_in,
  input wire logic [gpfgh_pkg::H_W-1:0] third_port_alt3_in
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  sequence s_wr(logic [31:0] a);
    psel && penable && pready && pwrite && paddr == a;
  endsequence
  chk_ready_once: assert property (pready |=> !pready) else $error("pready held too long");
  chk_ready_lat: assert property ($rose(psel && penable) |=> pready) else $error("late pready");
  chk_err_hole: assert property (pready && (paddr == 32'h5600_005C || paddr == 32'h5600_007C)
    |-> pslverr) else $error("hole without error");
  chk_idle_bus: assert property (!pready |-> prdata == 32'h0 && !pslverr) else $error("bus idle");
  chk_pull_inv: assert property (s_wr(ADDR_F_UP) |=> ##1
    {24'h0, ~first_port_pins_pullup_en} == ($past(pwdata, 2) & 32'h0000_00FF))
    else $error("pull-up not inverse of control");
  chk_drive_data: assert property (s_wr(ADDR_F_DAT) ##1 $stable(first_port_pins_oe) |=>
    {24'h0, first_port_pins_out & first_port_pins_oe} ==
    ($past(pwdata, 2) & {24'h0, first_port_pins_oe})) else $error("pad not data bit");
  chk_external_interrupt_line_first: assert property ((external_interrupt_line[7:0] &
    ~$past(first_port_pins_in)) == 8'h00) else $error("first line without pin");
  chk_external_interrupt_line_second: assert property ((external_interrupt_line[23:8] &
    ~$past(second_port_pins_in)) == 16'h0000) else $error("second line without pin");
  chk_alt3_mask: assert property ((second_port_alt3_in & ~G_ALT3_MASK) == 16'h0000 &&
    (third_port_alt3_in & ~H_ALT3_MASK) == 11'h000) else $error("reserved code passes");
  chk_pull_reset: assert property ($rose(rst_n) |-> first_port_pins_pullup_en == 8'hFF &&
    second_port_pins_pullup_en == 16'h03FF && third_port_pins_pullup_en == 11'h7FF)
    else $error("pull-up reset wrong");
endmodule
bind gpfgh_top gpfgh_top_monitor gpfgh_top_monitor_inst (.*);
`default_nettype wire

// ---- verification/tb_gpio_ports_f_g_h.sv ----
// Self-checking bench for the three-port GPIO block
`timescale 1ns/1ps
`default_nettype none
module tb_gpio_ports_f_g_h;
  import gpfgh_pkg::*;
  logic clk = 1'b0, rst_n = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0, pready, pslverr;
  logic [31:0] paddr = 32'h0, pwdata = 32'h0, prdata;
  logic [7:0] fi, fo, foe, fpu;
  logic [15:0] gi, go, goe, gpu, g3i, g3o = 16'h0000, g3e = 16'h0000;
  logic [10:0] hi, ho, hoe, hpu, h2i, h3i, h2o = 11'h000, h2e = 11'h000, h3o = 11'h000;
  logic [10:0] h3e = 11'h000;
  logic [23:0] irq;
  logic [31:0] ext[3], en[3], oa[3], ea[3], pa[3], om, d, u;
  int seed = 32'h66E5, miscompares = 0, n_compared = 0;
  localparam logic [31:0] MK[3] = '{32'h0000_00FF, 32'h0000_FFFF, 32'h0000_07FF};
  localparam logic [31:0] BASE[3] = '{ADDR_F_CON, ADDR_G_CON, ADDR_H_CON};
  localparam logic [31:0] URST[3] = '{{24'h0, F_UP_RST}, {16'h0, G_UP_RST}, {21'h0, H_UP_RST}};
  assign oa = '{{24'h0, fo}, {16'h0, go}, {21'h0, ho}};
  assign ea = '{{24'h0, foe}, {16'h0, goe}, {21'h0, hoe}};
  assign pa = '{{24'h0, fpu}, {16'h0, gpu}, {21'h0, hpu}};
  gpfgh_pins_model #(.W(F_W)) pins_f_inst (.clk(clk), .pad_out(fo), .pad_oe(foe), .pull_en(fpu),
    .ext_val(ext[0][7:0]), .ext_en(en[0][7:0]), .level(fi));
  gpfgh_pins_model #(.W(G_W)) pins_g_inst (.clk(clk), .pad_out(go), .pad_oe(goe), .pull_en(gpu),
    .ext_val(ext[1][15:0]), .ext_en(en[1][15:0]), .level(gi));
  gpfgh_pins_model #(.W(H_W)) pins_h_inst (.clk(clk), .pad_out(ho), .pad_oe(hoe), .pull_en(hpu),
    .ext_val(ext[2][10:0]), .ext_en(en[2][10:0]), .level(hi));
  gpfgh_top gpfgh_top_inst (.clk(clk), .rst_n(rst_n), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .first_port_pins_in(fi), .first_port_pins_out(fo),
    .first_port_pins_oe(foe), .first_port_pins_pullup_en(fpu), .second_port_pins_in(gi),
    .second_port_pins_out(go), .second_port_pins_oe(goe), .second_port_pins_pullup_en(gpu),
    .third_port_pins_in(hi), .third_port_pins_out(ho), .third_port_pins_oe(hoe),
    .third_port_pins_pullup_en(hpu), .external_interrupt_line(irq),
    .second_port_alt3_out(g3o), .second_port_alt3_oe(g3e), .second_port_alt3_in(g3i),
    .third_port_alt2_out(h2o), .third_port_alt2_oe(h2e), .third_port_alt2_in(h2i),
    .third_port_alt3_out(h3o), .third_port_alt3_oe(h3e), .third_port_alt3_in(h3i));
  initial forever #25 clk = ~clk;
  ////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
    n_compared++;
    if (got !== exp) begin
      miscompares++;
      $display("CHECK FAILED t=%0t %s got %h exp %h", $time, m, got, exp);
    end
  endtask
  // One gap cycle before each setup keeps every signal to one assignment per step
  task automatic xfer(input logic w, input logic [31:0] a, input logic [31:0] wd,
    output logic [31:0] rdat, output logic err);
    int n = 0;
    @(posedge clk);
    psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= wd;
    @(posedge clk);
    penable <= 1'b1;
    do begin @(posedge clk); n++; end while (pready !== 1'b1 && n < 20);
    rdat = prdata;
    err = pslverr;
    psel <= 1'b0; penable <= 1'b0;
    if (n >= 20) chk(32'h0, 32'h1, "no pready");
  endtask
  task automatic wr(input logic [31:0] a, input logic [31:0] wd);
    logic [31:0] r;
    logic e;
    xfer(1'b1, a, wd, r, e);
    chk({31'h0, e}, 32'h0, "write error");
  endtask
  task automatic rd(input logic [31:0] a, input logic [31:0] exp);
    logic [31:0] r;
    logic e;
    xfer(1'b0, a, 32'h0, r, e);
    chk(r, exp, "read data");
    chk({31'h0, e}, 32'h0, "read error");
  endtask
  function automatic logic [31:0] spread(input logic [31:0] m);
    logic [31:0] s = 32'h0;
    for (int i = 0; i < 16; i++) s[2*i] = m[i];
    return s;
  endfunction
  task automatic final_report();
    $display("compared %0d, mismatches %0d", n_compared, miscompares);
    if (miscompares == 0 && n_compared > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////
  initial begin
    logic [31:0] r;
    logic e;
    for (int p = 0; p < 3; p++) begin ext[p] = $random(seed); en[p] = 32'hFFFF_FFFF; end
    repeat (8) @(posedge clk);
    rst_n <= 1'b1;
    for (int p = 0; p < 3; p++) begin
      chk(pa[p], ~URST[p] & MK[p], "pull-up after reset");
      rd(BASE[p], 32'h0);
      rd(BASE[p] + 8, URST[p]);
      rd(BASE[p] + 4, ext[p] & MK[p]);
    end
    $display("test reset done");
    repeat (6) for (int p = 0; p < 3; p++) begin
      om = $random(seed) & MK[p]; d = $random(seed); u = $random(seed);
      ext[p] <= $random(seed);
      wr(BASE[p] + 4, d);
      wr(BASE[p], spread(om));
      wr(BASE[p] + 8, u);
      rd(BASE[p], spread(om));
      rd(BASE[p] + 4, ((d & om) | (ext[p] & ~om)) & MK[p]);
      rd(BASE[p] + 8, u & MK[p]);
      chk(oa[p] & ea[p], d & om, "pad value");
      chk(ea[p], om, "pad enable");
      chk(pa[p], ~u & MK[p], "pull-up enable");
    end
    $display("test random io done");
    for (int p = 0; p < 3; p++) begin
      en[p] <= 32'h0;
      wr(BASE[p], 32'h0);
      wr(BASE[p] + 8, 32'h0);
      rd(BASE[p] + 4, MK[p]);
      en[p] <= 32'hFFFF_FFFF;
    end
    xfer(1'b1, 32'h5600_005C, 32'hFFFF_FFFF, r, e);
    chk({31'h0, e}, 32'h1, "hole write error");
    xfer(1'b0, 32'h5600_007C, 32'h0, r, e);
    chk({31'h0, e}, 32'h1, "hole read error");
    $display("test pull-up and holes done");
    wr(ADDR_F_CON, 32'h0000_AAAA);
    wr(ADDR_G_CON, 32'hAAAA_AAAA);
    wr(ADDR_H_CON, 32'h003F_FFFF);
    repeat (2) @(posedge clk);
    chk({8'h0, irq}, {8'h0, ext[1][15:0], ext[0][7:0]}, "interrupt lines");
    chk({21'h0, h3i}, ext[2] & {21'h0, H_ALT3_MASK}, "third code 11 in");
    chk(ea[0] | ea[1] | ea[2], 32'h0, "function pins drive");
    wr(ADDR_G_CON, 32'h03FF_FFFF);
    wr(ADDR_H_CON, 32'h002A_AAAA);
    repeat (2) @(posedge clk);
    chk({16'h0, g3i}, ext[1] & {16'h0, G_ALT3_MASK}, "second code 11 in");
    chk({21'h0, h2i}, ext[2] & MK[2], "third code 10 in");
    g3e <= 16'hFFFF;
    g3o <= 16'($random(seed));
    h2e <= 11'h7FF;
    h2o <= 11'($random(seed));
    repeat (3) @(posedge clk);
    chk(ea[1], {16'h0, G_ALT3_MASK}, "second code 11 drive");
    chk(oa[1] & ea[1], {16'h0, g3o & G_ALT3_MASK}, "second code 11 value");
    chk(ea[2], MK[2], "third code 10 drive");
    chk(oa[2], {21'h0, h2o}, "third code 10 value");
    $display("test functions done");
    final_report();
  end
  initial begin
    repeat (5000) @(posedge clk);
    miscompares++;
    final_report();
  end
endmodule
`default_nettype wire
